// ===== sorc_ctrl.sv
`timescale 1ns/1ps
`include "sorc_params.svh"
// Functional notes
// - Range switch picks 5/6/8/10 V full scale
// - Reduced-range command forces 2 V full scale
// - Setpoint maps linearly onto output
// - Mains and power switch on at power-up enables output
// - Control logic runs regardless of power switch
// - Press while enabled disables, fires crowbar
// - Press while disabled clears faults, enables
// - Uncleared fault keeps output disabled
// - Detected fault disables power stage automatically
// - Disabled power stage always fires crowbar
// - Output above 12.5 V fires crowbar
// - 100 kHz PWM regulates output toward setpoint
// - Dissipative stage only while sinking energy
// - Indicators show fault, enable and range
// - Display shows only first detected fault
module sorc_ctrl
	import sorc_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = (`SORC_DEBOUNCE_US * (`SORC_CLK_HZ / 1000000)),
	parameter int NFAULT = 10
) (
	input wire logic clk,
	input wire logic reset,
	input sorc_pkg::sorc_wb_req_t wbReq,
	output sorc_pkg::sorc_wb_rsp_t wbRsp,
	input wire logic mainsOk,
	input wire logic powerSwitch,
	input wire logic toggleButton,
	input wire logic [1:0] range_select_switch,
	input wire logic [NFAULT-1:0] faultIn,
	input wire logic [15:0] sensedOutMv,
	output logic [3:0] bridgeGate,
	output logic crowbar,
	output logic dissipEnable,
	output sorc_pkg::sorc_leds_t leds,
	output logic irq
);
	import sorc_pkg::*;
	localparam int PWM_PERIOD = `SORC_CLK_HZ / `SORC_PWM_HZ;
	localparam int DBW = $clog2(DEBOUNCE_CYCLES + 1);
	// Refuse a fault count or debounce window that the counters cannot hold
	if (NFAULT < 1 || NFAULT > 15) begin : g_bad_nfault
		$error("sorc_ctrl: NFAULT out of range");
	end
	if (DEBOUNCE_CYCLES < 1) begin : g_bad_debounce
		$error("sorc_ctrl: DEBOUNCE_CYCLES too small");
	end

	// ==========================================================
	// Input synchronisers
	logic [1:0] btnS_q, mainsS_q, pswS_q;
	logic [1:0] rng0_q, rng1_q;
	logic [NFAULT-1:0] flt0_q, flt1_q;
	// Two stages on every asynchronous pin
	always_ff @(posedge clk) begin
		btnS_q <= {btnS_q[0], toggleButton};
		mainsS_q <= {mainsS_q[0], mainsOk};
		pswS_q <= {pswS_q[0], powerSwitch};
		rng0_q <= range_select_switch;
		rng1_q <= rng0_q;
		flt0_q <= faultIn;
		flt1_q <= flt0_q;
	end
	logic btnSync, supplyOn;
	assign btnSync = btnS_q[1];
	assign supplyOn = mainsS_q[1] && pswS_q[1];

	// ==========================================================
	// Button debounce
	logic [DBW-1:0] dbCnt_q;
	logic btnStable_q; // Accepted button level
	logic pressPulse; // One cycle at the accepted press edge
	// Level must hold steady for the whole window to be accepted
	always_ff @(posedge clk) begin
		if (reset) begin
			dbCnt_q <= '0;
			btnStable_q <= 1'b0;
		end else if (btnSync == btnStable_q) begin
			dbCnt_q <= '0;
		end else if (dbCnt_q == DBW'(DEBOUNCE_CYCLES - 1)) begin
			dbCnt_q <= '0;
			btnStable_q <= btnSync;
		end else begin
			dbCnt_q <= dbCnt_q + 1'b1;
		end
	end
	// Limitation: a press shorter than the window is never seen
	assign pressPulse = btnSync && !btnStable_q && (dbCnt_q == DBW'(DEBOUNCE_CYCLES - 1));

	// ==========================================================
	// Wishbone registers
	logic [31:0] ctrl_q; // Software control, bit 0 reduced range
	logic [15:0] setpt_q; // Signed setpoint, mV at input (+-10000)
	logic [`SORC_EV_WIDTH-1:0] irqStat_q, irqMask_q, events;
	logic wbHit;
	assign wbHit = wbReq.cyc && wbReq.stb && !wbRsp.ack;
	// Write side; byte lanes honoured
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q <= `SORC_CTRL_RESET_VAL;
			setpt_q <= '0;
			irqMask_q <= '0;
		end else if (wbHit && wbReq.we) begin
			for (int b = 0; b < 4; b++) begin
				if (wbReq.sel[b] && wbReq.adr == `SORC_ADDR_CTRL) ctrl_q[b*8 +: 8] <= wbReq.dat[b*8 +: 8];
			end
			if (wbReq.adr == `SORC_ADDR_SETPT) begin
				if (wbReq.sel[0]) setpt_q[7:0] <= wbReq.dat[7:0];
				if (wbReq.sel[1]) setpt_q[15:8] <= wbReq.dat[15:8];
			end
			if (wbReq.adr == `SORC_ADDR_IRQ_MASK && wbReq.sel[0]) begin
				irqMask_q <= wbReq.dat[`SORC_EV_WIDTH-1:0];
			end
		end
	end
	// Sticky status: a new event wins over a write-one clear
	always_ff @(posedge clk) begin
		if (reset) begin
			irqStat_q <= '0;
		end else if (wbHit && wbReq.we && wbReq.adr == `SORC_ADDR_IRQ_STAT && wbReq.sel[0]) begin
			irqStat_q <= (irqStat_q & ~wbReq.dat[`SORC_EV_WIDTH-1:0]) | events;
		end else begin
			irqStat_q <= irqStat_q | events;
		end
	end
	assign irq = |(irqStat_q & irqMask_q);
	logic reduced;
	assign reduced = ctrl_q[`SORC_CTRL_REDUCED];

	// ==========================================================
	// Full-scale decode
	logic [15:0] fsMv; // Output full scale in mV
	logic [7:0] fsAmp; // Current rating of the range
	// Reduced range overrides every range except a zero scale
	always_comb begin
		unique case (rng1_q)
			2'b00: begin fsMv = `SORC_FS_R00_MV; fsAmp = `SORC_FS_R00_A; end
			2'b01: begin fsMv = `SORC_FS_R01_MV; fsAmp = `SORC_FS_R01_A; end
			2'b10: begin fsMv = `SORC_FS_R10_MV; fsAmp = `SORC_FS_R10_A; end
			2'b11: begin fsMv = `SORC_FS_R11_MV; fsAmp = `SORC_FS_R11_A; end
		endcase
		if (reduced && fsMv != `SORC_FS_ZERO_MV) fsMv = `SORC_FS_REDUCED_MV;
	end
	// Target output = setpoint * fs / 10 V, signed
	logic signed [31:0] targetMv;
	logic signed [31:0] prod;
	assign prod = $signed(setpt_q) * $signed({16'h0000, fsMv});
	assign targetMv = prod / $signed({16'h0000, `SORC_SETPT_FS_MV});

	// ==========================================================
	// Enable and fault state machine
	sorc_state_t state_q;
	logic anyFault, overVolt;
	logic [NFAULT-1:0] faultLatch_q;
	assign overVolt = $signed(sensedOutMv) > $signed(`SORC_OVERVOLT_MV)
		|| $signed(sensedOutMv) < -$signed(`SORC_OVERVOLT_MV);
	assign anyFault = |flt1_q;
	// Faults latch until a press tries to clear them
	always_ff @(posedge clk) begin
		if (reset) begin
			faultLatch_q <= '0;
		end else if (pressPulse && state_q != SORC_ST_ON) begin
			faultLatch_q <= flt1_q; // only still-present faults survive
		end else begin
			faultLatch_q <= faultLatch_q | flt1_q;
		end
	end
	// Reset is the mains-present power-up; the logic never waits for the switch
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= SORC_ST_OFF;
		end else begin
			unique case (state_q)
				SORC_ST_OFF: begin
					if (anyFault) state_q <= SORC_ST_FAULT;
					else if (supplyOn) state_q <= SORC_ST_ON;
				end
				SORC_ST_ON: begin
					if (anyFault || !supplyOn) state_q <= SORC_ST_FAULT;
					else if (pressPulse) state_q <= SORC_ST_FAULT;
				end
				SORC_ST_FAULT: begin
					if (pressPulse && !anyFault && supplyOn) state_q <= SORC_ST_ON;
					else state_q <= SORC_ST_FAULT;
				end
			endcase
		end
	end
	logic stageOn;
	assign stageOn = (state_q == SORC_ST_ON);
	// Combinational so the bars are shorted in the same cycle as the trip
	assign crowbar = !stageOn || overVolt;
	logic stageOn_q;
	always_ff @(posedge clk) begin
		stageOn_q <= reset ? 1'b0 : stageOn;
	end
	assign events = {overVolt, stageOn_q && !stageOn, stageOn && !stageOn_q, anyFault};

	// ==========================================================
	// First-fault capture
	logic [3:0] firstFault_q; // 1-based index, zero for none
	// Held until a press clears all faults
	always_ff @(posedge clk) begin
		if (reset) begin
			firstFault_q <= '0;
		end else if (pressPulse && state_q != SORC_ST_ON && !anyFault) begin
			firstFault_q <= '0;
		end else if (firstFault_q == '0) begin
			// Scan downward so the lowest index wins a tie
			for (int i = NFAULT - 1; i >= 0; i--) begin
				if (flt1_q[i]) firstFault_q <= 4'(i + 1);
			end
		end
	end

	// ==========================================================
	// Regulator: integrating duty about mid-scale
	logic [15:0] duty_q; // 0..PWM_PERIOD, mid-scale means zero volts
	logic signed [31:0] err;
	logic signed [31:0] sensedWide; // Sensed output, sign extended
	// The sense word is two's complement; zero-filling would read -1 V as +64.5 V
	assign sensedWide = {{16{sensedOutMv[15]}}, sensedOutMv};
	assign err = targetMv - sensedWide;
	// Step duty by one count per clock toward the target
	always_ff @(posedge clk) begin
		if (reset || !stageOn) begin
			duty_q <= 16'(PWM_PERIOD / 2);
		end else if (err > 0 && duty_q < 16'(PWM_PERIOD)) begin
			duty_q <= duty_q + 16'h0001;
		end else if (err < 0 && duty_q > 16'h0000) begin
			duty_q <= duty_q - 16'h0001;
		end
	end
	sorc_pwm #(
		.PERIOD(PWM_PERIOD),
		.PHASES(4)
	) u_pwm (
		.clk(clk),
		.reset(reset),
		.run(stageOn),
		.duty(duty_q),
		.gate(bridgeGate)
	);
	// Sinking: the output must be pulled toward zero, or across it, against the load
	// Limitation: judged from voltage alone, as no output current is sensed here
	always_ff @(posedge clk) begin
		if (reset) dissipEnable <= 1'b0;
		else dissipEnable <= stageOn && ((sensedWide > 0 && targetMv < sensedWide)
			|| (sensedWide < 0 && targetMv > sensedWide));
	end

	// ==========================================================
	// Indicators and readback
	always_ff @(posedge clk) begin
		if (reset) begin
			leds <= '0;
		end else begin
			leds.faultLed <= (state_q == SORC_ST_FAULT) && (|faultLatch_q);
			leds.enableLed <= stageOn;
			leds.rangeLed <= rng1_q;
			leds.reducedLed <= reduced;
			leds.firstFault <= firstFault_q;
		end
	end
	// Single-cycle ack; unmapped reads return zero
	always_ff @(posedge clk) begin
		if (reset) begin
			wbRsp <= '0;
		end else begin
			wbRsp.ack <= wbHit;
			unique case (wbReq.adr)
				`SORC_ADDR_CTRL: wbRsp.dat <= ctrl_q;
				`SORC_ADDR_STATUS: wbRsp.dat <= {16'h0000, fsAmp, 2'b00, rng1_q, 2'(state_q), overVolt, crowbar};
				`SORC_ADDR_IRQ_STAT: wbRsp.dat <= 32'(irqStat_q);
				`SORC_ADDR_IRQ_MASK: wbRsp.dat <= 32'(irqMask_q);
				`SORC_ADDR_SETPT: wbRsp.dat <= {16'h0000, setpt_q};
				`SORC_ADDR_FBACK: wbRsp.dat <= {16'h0000, fsMv};
				`SORC_ADDR_FAULT: wbRsp.dat <= {12'h000, firstFault_q, 16'(faultLatch_q)};
				default: wbRsp.dat <= 32'h00000000;
			endcase
		end
	end

	// ==========================================================
	// Checks
	property p_crowbar_off;
		@(posedge clk) disable iff (reset) !stageOn |-> crowbar;
	endproperty
	a_crowbar_off: assert property (p_crowbar_off) else $error("crowbar idle while disabled");
	property p_fault_stop;
		@(posedge clk) disable iff (reset) anyFault |=> !stageOn;
	endproperty
	a_fault_stop: assert property (p_fault_stop) else $error("stage on after fault");
	property p_press_off;
		@(posedge clk) disable iff (reset) stageOn && pressPulse |=> !stageOn;
	endproperty
	a_press_off: assert property (p_press_off) else $error("press did not disable");
	property p_reduced;
		@(posedge clk) disable iff (reset) reduced |-> fsMv == `SORC_FS_REDUCED_MV;
	endproperty
	a_reduced: assert property (p_reduced) else $error("reduced scale wrong");
	property p_pwm_idle;
		@(posedge clk) disable iff (reset) !stageOn ##1 !stageOn |-> bridgeGate == 4'h0;
	endproperty
	a_pwm_idle: assert property (p_pwm_idle) else $error("gates run while disabled");
	property p_auto_on;
		@(posedge clk) disable iff (reset)
			state_q == SORC_ST_OFF && supplyOn && !anyFault |=> stageOn;
	endproperty
	a_auto_on: assert property (p_auto_on) else $error("no automatic enable");
	property p_stay_fault;
		@(posedge clk) disable iff (reset) state_q == SORC_ST_FAULT && anyFault |=> !stageOn;
	endproperty
	a_stay_fault: assert property (p_stay_fault) else $error("left fault state");
	property p_first_hold;
		@(posedge clk) disable iff (reset)
			firstFault_q != 0 && !pressPulse |=> $stable(firstFault_q);
	endproperty
	a_first_hold: assert property (p_first_hold) else $error("first fault changed");
	property p_ov_crowbar;
		@(posedge clk) disable iff (reset) overVolt |-> crowbar;
	endproperty
	a_ov_crowbar: assert property (p_ov_crowbar) else $error("crowbar idle on overvoltage");
	property p_press_on;
		@(posedge clk) disable iff (reset)
			state_q == SORC_ST_FAULT && pressPulse && !anyFault && supplyOn |=> stageOn;
	endproperty
	a_press_on: assert property (p_press_on) else $error("press did not re-enable");
	property p_one_press;
		@(posedge clk) disable iff (reset) pressPulse |=> !pressPulse;
	endproperty
	a_one_press: assert property (p_one_press) else $error("press acted twice");
	property p_dissip_off;
		@(posedge clk) disable iff (reset) !stageOn |=> !dissipEnable;
	endproperty
	a_dissip_off: assert property (p_dissip_off) else $error("dissipative stage on while off");
	property p_enable_led;
		@(posedge clk) disable iff (reset) stageOn |=> leds.enableLed;
	endproperty
	a_enable_led: assert property (p_enable_led) else $error("enable indicator dark");
endmodule // sorc_ctrl

// ===== sorc_operator.sv
`timescale 1ns/1ps
// ==========================================================
// Front-panel operator and output sense model
module sorc_operator (
	input wire logic clk,
	input wire logic [15:0] levelMv,
	output logic toggleButton,
	output logic [15:0] sensedOutMv
);
	// Output voltage is whatever level the bench imposes on the bars
	assign sensedOutMv = levelMv;
	// Button idles released
	initial begin
		toggleButton = 1'b0;
	end
	// One press with a contact bounce up front; the bounce is shorter than the window
	task automatic press();
		@(posedge clk);
		toggleButton <= 1'b1;
		repeat (2) @(posedge clk);
		toggleButton <= 1'b0;
		@(posedge clk);
		toggleButton <= 1'b1;
		repeat (16) @(posedge clk);
		toggleButton <= 1'b0;
		// Leave time for the debounced edge to act
		repeat (8) @(posedge clk);
	endtask
endmodule // sorc_operator

// ===== sorc_params.svh
`ifndef SORC_PARAMS_SVH
`define SORC_PARAMS_SVH
// Register byte offsets
`define SORC_ADDR_CTRL 8'h00
`define SORC_ADDR_STATUS 8'h04
`define SORC_ADDR_IRQ_STAT 8'h08
`define SORC_ADDR_IRQ_MASK 8'h0c
`define SORC_ADDR_SETPT 8'h10
`define SORC_ADDR_FBACK 8'h14
`define SORC_ADDR_FAULT 8'h18
// Control register fields
`define SORC_CTRL_REDUCED 0
`define SORC_CTRL_RESET_VAL 32'h00000000
// Event bit positions in interrupt status
`define SORC_EV_FAULT 0
`define SORC_EV_ENABLE 1
`define SORC_EV_DISABLE 2
`define SORC_EV_OVERVOLT 3
`define SORC_EV_WIDTH 4
// Full scale in millivolts per range code
`define SORC_FS_R00_MV 16'd5000
`define SORC_FS_R01_MV 16'd6000
`define SORC_FS_R10_MV 16'd8000
`define SORC_FS_R11_MV 16'd10000
`define SORC_FS_REDUCED_MV 16'd2000
`define SORC_FS_ZERO_MV 16'd0
// Full-scale current in amperes per range code
`define SORC_FS_R00_A 8'd120
`define SORC_FS_R01_A 8'd100
`define SORC_FS_R10_A 8'd75
`define SORC_FS_R11_A 8'd60
// Setpoint input full scale, millivolts
`define SORC_SETPT_FS_MV 16'd10000
// Overvoltage trip, millivolts
`define SORC_OVERVOLT_MV 16'd12500
// Timing
`define SORC_CLK_HZ 50000000
`define SORC_PWM_HZ 100000
`define SORC_DEBOUNCE_US 10000
`endif

// ===== sorc_pkg.sv
package sorc_pkg;
	// Enable/fault state of the output
	typedef enum logic [1:0] {
		SORC_ST_OFF,
		SORC_ST_ON,
		SORC_ST_FAULT
	} sorc_state_t;
	// Classic Wishbone request from master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} sorc_wb_req_t;
	// Wishbone answer
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} sorc_wb_rsp_t;
	// Front-panel indicators
	typedef struct packed {
		logic faultLed;
		logic enableLed;
		logic [1:0] rangeLed;
		logic reducedLed;
		logic [3:0] firstFault;
	} sorc_leds_t;
endpackage

// ===== sorc_pwm.sv
`timescale 1ns/1ps
`include "sorc_params.svh"
// ==========================================================
// PWM carrier generator for one H-bridge phase group
module sorc_pwm #(
	parameter int PERIOD = 500,
	parameter int PHASES = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [15:0] duty,
	output logic [PHASES-1:0] gate
);
	localparam int CW = $clog2(PERIOD);
	logic [CW-1:0] cnt_q; // Shared carrier counter
	// Refuse a carrier too short to count or no phase at all
	if (PERIOD < 2 || PHASES < 1) begin : g_bad_param
		$error("sorc_pwm: bad parameters");
	end
	// Free-running carrier so edges stay periodic
	always_ff @(posedge clk) begin
		if (reset || cnt_q == CW'(PERIOD - 1)) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	// Each phase shifted by a fraction of the period to spread ripple
	genvar g;
	generate
		for (g = 0; g < PHASES; g++) begin : g_ph
			logic [CW:0] ph;
			logic [CW:0] shifted;
			assign ph = (CW+1)'(cnt_q) + (CW+1)'((PERIOD * g) / PHASES);
			assign shifted = (ph >= (CW+1)'(PERIOD)) ? ph - (CW+1)'(PERIOD) : ph;
			always_ff @(posedge clk) begin
				if (reset || !run) begin
					gate[g] <= 1'b0;
				end else begin
					gate[g] <= (17'(shifted) < 17'(duty));
				end
			end
		end
	endgenerate
endmodule // sorc_pwm

// ===== supply_output_state_range_control_bench.sv
`timescale 1ns/1ps
`include "sorc_params.svh"
// ==========================================================
// Self-checking bench for the output state and range control
module supply_output_state_range_control_bench;
	import sorc_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1; // Held for ten cycles at start
	sorc_wb_req_t req = '0;
	sorc_wb_rsp_t rsp;
	logic mainsOk = 1'b0;
	logic powerSwitch = 1'b0;
	logic [1:0] rangeSel = 2'h0;
	logic [9:0] faultIn = 10'h000;
	logic [15:0] levelMv = 16'h0000;
	logic toggleButton;
	logic [15:0] sensedOutMv;
	logic [3:0] bridgeGate;
	logic crowbar;
	logic dissipEnable;
	sorc_leds_t leds;
	logic irq;
	int miscompares = 0;
	int tests_run = 0;
	logic [15:0] fsMv [4] = '{`SORC_FS_R00_MV, `SORC_FS_R01_MV, `SORC_FS_R10_MV, `SORC_FS_R11_MV};
	logic [7:0] fsA [4] = '{`SORC_FS_R00_A, `SORC_FS_R01_A, `SORC_FS_R10_A, `SORC_FS_R11_A};
	// ==========================================================
	// Clock, 20 ns period
	always #10 clk = ~clk;
	// Short debounce keeps presses quick
	sorc_ctrl #(.DEBOUNCE_CYCLES(4), .NFAULT(10)) DUT (.clk(clk), .reset(reset), .wbReq(req),
		.wbRsp(rsp), .mainsOk(mainsOk), .powerSwitch(powerSwitch), .toggleButton(toggleButton),
		.range_select_switch(rangeSel), .faultIn(faultIn), .sensedOutMv(sensedOutMv),
		.bridgeGate(bridgeGate), .crowbar(crowbar), .dissipEnable(dissipEnable), .leds(leds),
		.irq(irq));
	sorc_operator OP (.clk(clk), .levelMv(levelMv), .toggleButton(toggleButton),
		.sensedOutMv(sensedOutMv));
	// ==========================================================
	// Checking and closing
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
			miscompares++;
		end
	endtask
	task automatic final_report();
		if (miscompares == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ==========================================================
	// Classic Wishbone cycle; holds until ack, bounded so a dead slave ends the run
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: wd};
		do begin
			@(posedge clk);
			n++;
		end while (rsp.ack !== 1'b1 && n < 20);
		rd = rsp.dat;
		req <= '0;
		if (n >= 20) begin
			miscompares++;
			final_report();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		wb(1'b1, a, d, x);
	endtask
	// Read, keep only the field of interest, compare
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] x;
		wb(1'b0, a, 32'h0, x);
		chk(nm, x & m, e);
	endtask
	// Rising edge to rising edge of the first gate, in cycles
	task automatic pwmPeriod();
		int n;
		int t0;
		n = 0;
		t0 = 0;
		for (int e = 0; e < 2; e++) begin
			while (bridgeGate[0] !== 1'b0 && n < 3000) begin
				@(negedge clk);
				n++;
			end
			while (bridgeGate[0] !== 1'b1 && n < 3000) begin
				@(negedge clk);
				n++;
			end
			if (e == 0) begin
				t0 = n;
			end
		end
		if (n >= 3000) begin
			miscompares++;
			final_report();
		end
		chk("pwmPeriod", n - t0, `SORC_CLK_HZ / `SORC_PWM_HZ);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk("ack", rsp.ack, 0);
		chk("crowbarOff", crowbar, 1);
		chk("dissip", dissipEnable, 0);
		chk("irq", irq, 0);
		rdc("ctrl", `SORC_ADDR_CTRL, 32'hffffffff, `SORC_CTRL_RESET_VAL);
		rdc("mask", `SORC_ADDR_IRQ_MASK, 32'hf, 0);
		// Unmapped place ignores writes and reads zero
		wr(8'h1c, 32'hffffffff);
		rdc("unmapped", 8'h1c, 32'hffffffff, 0);
		// Every range code, then the reduced command on the last
		for (int r = 0; r < 4; r++) begin
			@(posedge clk);
			rangeSel <= r[1:0];
			repeat (4) @(posedge clk);
			rdc("fsMv", `SORC_ADDR_FBACK, 32'hffff, fsMv[r]);
			rdc("fsAmp", `SORC_ADDR_STATUS, 32'hff30, {fsA[r], 2'h0, r[1:0], 4'h0});
			chk("rangeLed", leds.rangeLed, r);
		end
		wr(`SORC_ADDR_CTRL, 32'h1);
		rdc("fsLow", `SORC_ADDR_FBACK, 32'hffff, `SORC_FS_REDUCED_MV);
		chk("lowLed", leds.reducedLed, 1);
		wr(`SORC_ADDR_CTRL, 32'h0);
		rdc("fsBack", `SORC_ADDR_FBACK, 32'hffff, `SORC_FS_R11_MV);
		wr(`SORC_ADDR_SETPT, 32'hffffd8f0);
		rdc("setpt", `SORC_ADDR_SETPT, 32'hffff, 32'hd8f0);
		wr(`SORC_ADDR_SETPT, 32'h0);
		// Power up enables on its own and raises the enabled event
		wr(`SORC_ADDR_IRQ_MASK, 32'h2);
		@(posedge clk);
		mainsOk <= 1'b1;
		powerSwitch <= 1'b1;
		repeat (8) @(posedge clk);
		@(negedge clk);
		chk("enLed", leds.enableLed, 1);
		chk("crowbarOn", crowbar, 0);
		chk("irqEn", irq, 1);
		rdc("statOn", `SORC_ADDR_STATUS, 32'hff3f, 32'h3c34);
		wr(`SORC_ADDR_IRQ_STAT, 32'h2);
		@(negedge clk);
		chk("irqClr", irq, 0);
		pwmPeriod();
		// Disable by press; masked event must not interrupt until unmasked
		wr(`SORC_ADDR_IRQ_MASK, 32'h0);
		OP.press();
		chk("crowbarDis", crowbar, 1);
		chk("gatesOff", bridgeGate, 4'h0);
		chk("irqMasked", irq, 0);
		rdc("statDis", `SORC_ADDR_STATUS, 32'hc, 32'h8);
		rdc("evDis", `SORC_ADDR_IRQ_STAT, 32'h4, 32'h4);
		wr(`SORC_ADDR_IRQ_MASK, 32'h4);
		@(negedge clk);
		chk("irqUnmask", irq, 1);
		wr(`SORC_ADDR_IRQ_STAT, 32'hf);
		@(negedge clk);
		chk("irqW1c", irq, 0);
		OP.press();
		rdc("statRe", `SORC_ADDR_STATUS, 32'hc, 32'h4);
		// Positive target above a zero output is sourcing
		wr(`SORC_ADDR_SETPT, 32'h1388);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("dissipSrc", dissipEnable, 0);
		@(posedge clk);
		// Overvoltage both polarities, threshold itself is no trip
		levelMv <= 16'd12501;
		repeat (6) @(posedge clk);
		rdc("ovTrip", `SORC_ADDR_STATUS, 32'hf, 32'h7);
		chk("dissipSink", dissipEnable, 1);
		levelMv <= 16'd12500;
		repeat (6) @(posedge clk);
		chk("ovEdge", crowbar, 0);
		levelMv <= 16'hcf2b;
		repeat (6) @(posedge clk);
		chk("ovNeg", crowbar, 1);
		levelMv <= 16'h0000;
		// Two faults a few cycles apart; the earlier one is shown
		faultIn[5] <= 1'b1;
		repeat (4) @(posedge clk);
		faultIn[2] <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk("crowbarFlt", crowbar, 1);
		chk("fltLed", leds.faultLed, 1);
		chk("firstLed", leds.firstFault, 6);
		rdc("firstReg", `SORC_ADDR_FAULT, 32'hf0000, 32'h60000);
		OP.press();
		rdc("stuck", `SORC_ADDR_STATUS, 32'hc, 32'h8);
		faultIn <= 10'h000;
		repeat (4) @(posedge clk);
		OP.press();
		rdc("cleared", `SORC_ADDR_STATUS, 32'hc, 32'h4);
		chk("firstClr", leds.firstFault, 0);
		// Bulk switch off: logic keeps answering and shows the fault
		powerSwitch <= 1'b0;
		repeat (8) @(posedge clk);
		rdc("bulkOff", `SORC_ADDR_STATUS, 32'hc, 32'h8);
		powerSwitch <= 1'b1;
		repeat (8) @(posedge clk);
		OP.press();
		// Blackout recovery: a fresh reset comes back enabled
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (8) @(posedge clk);
		rdc("recover", `SORC_ADDR_STATUS, 32'hc, 32'h4);
		final_report();
	end
endmodule // supply_output_state_range_control_bench
